//--- spwm_pkg.sv
package spwm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CHANNEL_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_TIMEBASE_SEL      = 8'h04;
	localparam logic [7:0] OFS_DUTY_LOW_BYTE     = 8'h08;
	localparam logic [7:0] OFS_DUTY_SHADOW_HIGH  = 8'h0C;
	localparam logic [7:0] OFS_PIN_LOC_SEL_B     = 8'h10;
	localparam logic [7:0] OFS_PIN_DIRECTION     = 8'h14;
	localparam logic [7:0] OFS_TB_BASE           = 8'h20;
	localparam logic [7:0] OFS_TB_STRIDE         = 8'h10;
	localparam logic [7:0] OFS_TB_PERIOD         = 8'h00;
	localparam logic [7:0] OFS_TB_CONTROL        = 8'h04;
	localparam logic [7:0] OFS_TB_COUNT          = 8'h08;
	localparam logic [7:0] OFS_TB_FLAG           = 8'h0C;

	// Field positions
	localparam int CTL_MODE_LSB   = 0;
	localparam int CTL_DLSB_LSB   = 4;
	localparam int TBC_PSC_LSB    = 0;
	localparam int TBC_RUN_BIT    = 2;
	localparam int TBC_POST_LSB   = 3;
	localparam int TSEL_CH_LSB    = 0;
	localparam int PLOC_CH_BIT    = 0;
	localparam int PDIR_CH_BIT    = 0;

	// Reset values
	localparam logic [7:0] RST_CHANNEL_CONTROL = 8'h00;
	localparam logic [7:0] RST_TIMEBASE_SEL    = 8'h00;
	localparam logic [7:0] RST_DUTY_LOW_BYTE   = 8'h00;
	localparam logic [7:0] RST_PIN_LOC_SEL_B   = 8'h00;
	localparam logic [7:0] RST_PIN_DIRECTION   = 8'h01;
	localparam logic [7:0] RST_TB_PERIOD       = 8'hFF;
	localparam logic [7:0] RST_TB_CONTROL      = 8'h00;

	// Mode encoding for standard PWM; integrator may change it
	localparam logic [3:0] MODE_PWM = 4'hC;

	// Prescaler field encodings
	localparam logic [1:0] PSC_DIV1  = 2'h0;
	localparam logic [1:0] PSC_DIV4  = 2'h1;

	// Last prescaler phase for each ratio: 4, 16 or 64 clocks per increment
	localparam logic [5:0] PSC_LAST_DIV1  = 6'h03;
	localparam logic [5:0] PSC_LAST_DIV4  = 6'h0F;
	localparam logic [5:0] PSC_LAST_DIV16 = 6'h3F;

	// Number of period timers
	localparam int NUM_TIMEBASES = 3;

	// Live time base of one period timer
	typedef struct packed {
		logic [7:0] count;
		logic [1:0] low2;
		logic       period_start;
	} spwm_tb_t;

	// Software-owned timer settings
	typedef struct packed {
		logic [7:0] period;
		logic       run;
		logic [1:0] prescale;
	} spwm_tbcfg_t;

endpackage

//--- spwm_timebase.sv
`timescale 1ns/1ps
module spwm_timebase (
	input  wire logic                 clk_sys_i,
	input  wire logic                 rstn_i,
	input  wire logic                 sleep_i,
	input  wire spwm_pkg::spwm_tbcfg_t cfg_i,
	input  wire logic                 count_wr_i,
	input  wire logic [7:0]           count_wdata_i,
	input  wire logic                 flag_clr_i,
	output spwm_pkg::spwm_tb_t        tb_o,
	output logic                      flag_o
);

	logic [5:0] psc;
	logic [5:0] psc_last;
	logic       tick;
	logic       match;

	// Last prescaler phase: 4, 16 or 64 clocks per increment
	assign psc_last = (cfg_i.prescale == spwm_pkg::PSC_DIV1) ? spwm_pkg::PSC_LAST_DIV1 :
		(cfg_i.prescale == spwm_pkg::PSC_DIV4) ? spwm_pkg::PSC_LAST_DIV4 :
		spwm_pkg::PSC_LAST_DIV16;
	assign tick  = cfg_i.run && !sleep_i && (psc == psc_last);
	assign match = tick && (tb_o.count == cfg_i.period);

	// Prescaler and 8-bit count; postscaler plays no part here
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			psc  <= 6'h00;
			tb_o <= '0;
		end else begin
			if (cfg_i.run && !sleep_i) begin
				psc <= (psc == psc_last) ? 6'h00 : psc + 6'h01;
			end
			tb_o.period_start <= match;
			if (count_wr_i) begin
				tb_o.count <= count_wdata_i;
			end else if (match) begin
				tb_o.count <= 8'h00;
			end else if (tick) begin
				tb_o.count <= tb_o.count + 8'h01;
			end
			// Low bits of the 10-bit base: clock phase or prescaler bits
			tb_o.low2 <= (cfg_i.prescale == spwm_pkg::PSC_DIV1) ? next_low(psc, 0) :
				(cfg_i.prescale == spwm_pkg::PSC_DIV4) ? next_low(psc, 2) :
				next_low(psc, 4);
		end
	end

	// Phase bits as they stand after this edge
	function automatic logic [1:0] next_low(input logic [5:0] p, input int sh);
		logic [5:0] n;
		n = (!cfg_i.run || sleep_i) ? p : ((p == psc_last) ? 6'h00 : p + 6'h01);
		next_low = 2'(n >> sh);
	endfunction

	// Period flag; a match beats a clear in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			flag_o <= 1'b0;
		end else if (match) begin
			flag_o <= 1'b1;
		end else if (flag_clr_i) begin
			flag_o <= 1'b0;
		end
	end

endmodule

//--- spwm_channel.sv
`timescale 1ns/1ps
module spwm_channel (
	input  wire logic               clk_sys_i,
	input  wire logic               rstn_i,
	input  wire logic               sleep_i,
	input  wire logic               active_i,
	input  wire spwm_pkg::spwm_tb_t tb_i,
	input  wire logic [7:0]         period_i,
	input  wire logic [7:0]         duty_low_i,
	input  wire logic [1:0]         duty_lsb_pair_i,
	input  wire logic               shadow_wr_i,
	input  wire logic [7:0]         shadow_wdata_i,
	output logic [7:0]              duty_shadow_high_o,
	output logic                    pwm_o
);

	logic [1:0]  latch2;
	logic [9:0]  next_duty;
	logic [10:0] span;
	logic        over;
	logic        hit;

	assign next_duty = {duty_low_i, duty_lsb_pair_i};
	assign span      = {1'b0, period_i, 2'h0} + 11'h004;
	assign over      = {1'b0, next_duty} > span;
	assign hit       = ({tb_i.count, tb_i.low2} == {duty_shadow_high_o, latch2});

	// Double buffer and output; frozen in sleep
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			duty_shadow_high_o <= 8'h00;
			latch2             <= 2'h0;
			pwm_o              <= 1'b0;
		end else if (!sleep_i) begin
			if (!active_i) begin
				pwm_o <= 1'b0;
				if (shadow_wr_i) begin
					duty_shadow_high_o <= shadow_wdata_i;
				end
			end else if (tb_i.period_start) begin
				duty_shadow_high_o <= duty_low_i;
				latch2             <= duty_lsb_pair_i;
				if (!over) begin
					pwm_o <= (next_duty != 10'h000);
				end
			end else if (hit) begin
				// Latched duty only; a pending oversized write must not skip this clear
				pwm_o <= 1'b0;
			end
		end
	end

endmodule

//--- spwm_top.sv
// Function
// - One of three timers gives period base
// - Period is (period+1) x4 x prescale clocks
// - After match: clear count, latch duty
// - Period start sets output unless duty zero or beyond period
// - Postscaler never affects PWM timing
// - Duty: eight bits low byte, two control
// - Duty writes anytime; applied at period end
// - Shadow high byte read-only in PWM
// - High time is duty times prescaled clock
// - Shadow plus two-bit latch double-buffer duty
// - Time base: count plus phase/prescaler bits
// - Base equals duty: output goes low
// - Resolution follows period, ten bits max
// - Duty beyond period leaves pin unchanged
// - Sleep freezes count, state and output
// - Reset: pin input, registers reset
// - Prescaler divides by 1, 4, 16
// - Timing scales with system clock
// - Output pin relocatable by location select
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module spwm_top (
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        sleep_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             pin_a_o,
	output logic             pin_a_oe_n_o,
	output logic             pin_b_o,
	output logic             pin_b_oe_n_o
);

	localparam int NTB = spwm_pkg::NUM_TIMEBASES;

	// Software registers
	logic [7:0] channel_control;
	logic [7:0] timebase_selection;
	logic [7:0] duty_low_byte;
	logic [7:0] pin_location_select_b;
	logic [7:0] pin_direction;
	logic [7:0] period_compare   [NTB];
	logic [7:0] timebase_control [NTB];

	// Block state seen by software
	logic [7:0]          duty_shadow_high;
	logic                pwm_level;
	spwm_pkg::spwm_tb_t  tb       [NTB];
	logic                tb_flag  [NTB];
	spwm_pkg::spwm_tbcfg_t tb_cfg [NTB];

	// Bus request decode
	logic       req;
	logic       wr_stb;
	logic       wr_lane0;
	logic       hit_ctl;
	logic       hit_tsel;
	logic       hit_dlow;
	logic       hit_dsh;
	logic       hit_ploc;
	logic       hit_pdir;
	logic [NTB-1:0] hit_per;
	logic [NTB-1:0] hit_tbc;
	logic [NTB-1:0] hit_cnt;
	logic [NTB-1:0] hit_flg;
	logic [7:0] next_rdata;

	// Channel routing
	logic [1:0] channel_timer_select;
	logic [1:0] tb_index;
	logic [3:0] channel_mode_field;
	logic [1:0] duty_lsb_pair;
	logic       pwm_active;
	logic       pin_released;
	spwm_pkg::spwm_tb_t sel_tb;
	logic [7:0] sel_period;
	logic       next_oe_n;

	// Address match helper
	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
		is_addr = (a[7:2] == ofs[7:2]);
	endfunction

	// Address of one timer register
	function automatic logic [7:0] tb_addr(input int i, input logic [7:0] ofs);
		tb_addr = spwm_pkg::OFS_TB_BASE + 8'(i * spwm_pkg::OFS_TB_STRIDE) + ofs;
	endfunction

	// Request qualifies while no ack is pending
	assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_stb   = req && wb_we_i;
	assign wr_lane0 = wr_stb && wb_sel_i[0];

	// Channel-level register hits
	assign hit_ctl  = is_addr(wb_adr_i, spwm_pkg::OFS_CHANNEL_CONTROL);
	assign hit_tsel = is_addr(wb_adr_i, spwm_pkg::OFS_TIMEBASE_SEL);
	assign hit_dlow = is_addr(wb_adr_i, spwm_pkg::OFS_DUTY_LOW_BYTE);
	assign hit_dsh  = is_addr(wb_adr_i, spwm_pkg::OFS_DUTY_SHADOW_HIGH);
	assign hit_ploc = is_addr(wb_adr_i, spwm_pkg::OFS_PIN_LOC_SEL_B);
	assign hit_pdir = is_addr(wb_adr_i, spwm_pkg::OFS_PIN_DIRECTION);

	// Per-timer register hits
	genvar g;
	generate
		for (g = 0; g < NTB; g++) begin : g_hit
			assign hit_per[g] = is_addr(wb_adr_i, tb_addr(g, spwm_pkg::OFS_TB_PERIOD));
			assign hit_tbc[g] = is_addr(wb_adr_i, tb_addr(g, spwm_pkg::OFS_TB_CONTROL));
			assign hit_cnt[g] = is_addr(wb_adr_i, tb_addr(g, spwm_pkg::OFS_TB_COUNT));
			assign hit_flg[g] = is_addr(wb_adr_i, tb_addr(g, spwm_pkg::OFS_TB_FLAG));
		end
	endgenerate

	// Control fields
	assign channel_mode_field = channel_control[spwm_pkg::CTL_MODE_LSB +: 4];
	assign duty_lsb_pair      = channel_control[spwm_pkg::CTL_DLSB_LSB +: 2];
	assign pwm_active         = (channel_mode_field == spwm_pkg::MODE_PWM);
	assign pin_released       = (channel_control == 8'h00);
	assign channel_timer_select = timebase_selection[spwm_pkg::TSEL_CH_LSB +: 2];

	// Encoding 3 is unassigned and falls back to the first timer
	assign tb_index   = (channel_timer_select == 2'h3) ? 2'h0 : channel_timer_select;
	assign sel_tb     = tb[tb_index];
	assign sel_period = period_compare[tb_index];

	// Pin is driven only in PWM with direction bit cleared
	assign next_oe_n = pin_direction[spwm_pkg::PDIR_CH_BIT] || pin_released
		|| !pwm_active;

	// Read data multiplexer; unmapped reads return zero
	always_comb begin
		next_rdata = 8'h00;
		if (hit_ctl) begin
			next_rdata = channel_control;
		end
		if (hit_tsel) begin
			next_rdata = timebase_selection;
		end
		if (hit_dlow) begin
			next_rdata = duty_low_byte;
		end
		if (hit_dsh) begin
			next_rdata = duty_shadow_high;
		end
		if (hit_ploc) begin
			next_rdata = pin_location_select_b;
		end
		if (hit_pdir) begin
			next_rdata = pin_direction;
		end
		for (int i = 0; i < NTB; i++) begin
			if (hit_per[i]) begin
				next_rdata = period_compare[i];
			end
			if (hit_tbc[i]) begin
				next_rdata = timebase_control[i];
			end
			if (hit_cnt[i]) begin
				next_rdata = tb[i].count;
			end
			if (hit_flg[i]) begin
				next_rdata = {7'h00, tb_flag[i]};
			end
		end
	end

	// Bus answer one cycle after the request is seen
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? {24'h000000, next_rdata} : 32'h00000000;
		end
	end

	// Channel registers; duty parts are written freely
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			channel_control       <= spwm_pkg::RST_CHANNEL_CONTROL;
			timebase_selection    <= spwm_pkg::RST_TIMEBASE_SEL;
			duty_low_byte         <= spwm_pkg::RST_DUTY_LOW_BYTE;
			pin_location_select_b <= spwm_pkg::RST_PIN_LOC_SEL_B;
			pin_direction         <= spwm_pkg::RST_PIN_DIRECTION;
		end else if (wr_lane0) begin
			if (hit_ctl) begin
				channel_control <= wb_dat_i[7:0];
			end
			if (hit_tsel) begin
				timebase_selection <= wb_dat_i[7:0];
			end
			if (hit_dlow) begin
				duty_low_byte <= wb_dat_i[7:0];
			end
			if (hit_ploc) begin
				pin_location_select_b <= wb_dat_i[7:0];
			end
			if (hit_pdir) begin
				pin_direction <= wb_dat_i[7:0];
			end
		end
	end

	// Timer settings registers
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NTB; i++) begin
				period_compare[i]   <= spwm_pkg::RST_TB_PERIOD;
				timebase_control[i] <= spwm_pkg::RST_TB_CONTROL;
			end
		end else if (wr_lane0) begin
			for (int i = 0; i < NTB; i++) begin
				if (hit_per[i]) begin
					period_compare[i] <= wb_dat_i[7:0];
				end
				if (hit_tbc[i]) begin
					timebase_control[i] <= {1'b0, wb_dat_i[6:0]};
				end
			end
		end
	end

	// Three period timers; postscaler bits are stored only
	generate
		for (g = 0; g < NTB; g++) begin : g_tb
			assign tb_cfg[g].period   = period_compare[g];
			assign tb_cfg[g].run      = timebase_control[g][spwm_pkg::TBC_RUN_BIT];
			assign tb_cfg[g].prescale = timebase_control[g][spwm_pkg::TBC_PSC_LSB +: 2];

			spwm_timebase u_tb (
				.clk_sys_i     (clk_sys_i),
				.rstn_i        (rstn_i),
				.sleep_i       (sleep_i),
				.cfg_i         (tb_cfg[g]),
				.count_wr_i    (wr_lane0 && hit_cnt[g]),
				.count_wdata_i (wb_dat_i[7:0]),
				.flag_clr_i    (wr_lane0 && hit_flg[g] && wb_dat_i[0]),
				.tb_o          (tb[g]),
				.flag_o        (tb_flag[g])
			);
		end
	endgenerate

	// Standard PWM channel; shadow writable only outside PWM
	spwm_channel u_ch (
		.clk_sys_i          (clk_sys_i),
		.rstn_i             (rstn_i),
		.sleep_i            (sleep_i),
		.active_i           (pwm_active),
		.tb_i               (sel_tb),
		.period_i           (sel_period),
		.duty_low_i         (duty_low_byte),
		.duty_lsb_pair_i    (duty_lsb_pair),
		.shadow_wr_i        (wr_lane0 && hit_dsh && !pwm_active),
		.shadow_wdata_i     (wb_dat_i[7:0]),
		.duty_shadow_high_o (duty_shadow_high),
		.pwm_o              (pwm_level)
	);

	// Pin placement; sleep holds the driven level
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			pin_a_o      <= 1'b0;
			pin_b_o      <= 1'b0;
			pin_a_oe_n_o <= 1'b1;
			pin_b_oe_n_o <= 1'b1;
		end else if (!sleep_i) begin
			if (pin_location_select_b[spwm_pkg::PLOC_CH_BIT]) begin
				pin_a_o      <= 1'b0;
				pin_a_oe_n_o <= 1'b1;
				pin_b_o      <= pwm_level;
				pin_b_oe_n_o <= next_oe_n;
			end else begin
				pin_a_o      <= pwm_level;
				pin_a_oe_n_o <= next_oe_n;
				pin_b_o      <= 1'b0;
				pin_b_oe_n_o <= 1'b1;
			end
		end
	end

endmodule

//--- spwm_monitor.sv
`timescale 1ns/1ps
module spwm_monitor (
	input wire logic        clk_sys_i,
	input wire logic        rstn_i,
	input wire logic        sleep_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        pin_a_o,
	input wire logic        pin_a_oe_n_o,
	input wire logic        pin_b_o,
	input wire logic        pin_b_oe_n_o
);
	default clocking dc @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	// Request taken by the slave, and a settled sleep
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_asleep;
		sleep_i [*3];
	endsequence

	// Bus answer, pin state after reset, pin position and sleep hold
	chk_ack_next: assert property (s_req |=> wb_ack_o)
		else $error("ack late");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not idle");
	chk_dat_width: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_reset_out: assert property ($rose(rstn_i) |-> pin_a_oe_n_o && pin_b_oe_n_o)
		else $error("pins not input after reset");
	chk_one_pos: assert property (!pin_a_oe_n_o |-> pin_b_oe_n_o)
		else $error("both positions driven");
	chk_sleep_hold: assert property (s_asleep |-> $stable(pin_a_o) && $stable(pin_b_o))
		else $error("pin moved in sleep");
endmodule

bind spwm_top spwm_monitor u_mon (
	.clk_sys_i, .rstn_i, .sleep_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_a_o, .pin_a_oe_n_o, .pin_b_o, .pin_b_oe_n_o
);

//--- spwm_load.sv
`timescale 1ns/1ps
module spwm_load (
	input  wire logic   clk_sys_i,
	input  wire logic   pin_a_i,
	input  wire logic   pin_a_oe_n_i,
	input  wire logic   pin_b_i,
	input  wire logic   pin_b_oe_n_i,
	output logic        level_o,
	output logic [15:0] hi_o,
	output logic [15:0] per_o,
	output logic [15:0] rises_o
);
	logic        last = 1'b0;
	logic [15:0] hcnt = 16'h0000;
	logic [15:0] pcnt = 16'h0000;
	logic [15:0] nr   = 16'h0000;
	logic        up;

	// The load pulls the wire down when no position drives it
	assign level_o = (!pin_a_oe_n_i && pin_a_i) || (!pin_b_oe_n_i && pin_b_i);
	assign up = level_o && !last;
	assign rises_o = nr;

	// Each rising edge closes a period: keep its length and high time
	always @(posedge clk_sys_i) begin
		last <= level_o;
		pcnt <= up ? 16'h0001 : pcnt + 16'h0001;
		hcnt <= up ? 16'h0001 : hcnt + 16'(level_o);
		if (up) begin
			per_o <= pcnt;
			hi_o <= hcnt;
			nr <= nr + 16'h0001;
		end
	end
endmodule

//--- spwm_tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i    = 1'b0;
	logic        sleep_i   = 1'b0;
	logic        wb_cyc_i  = 1'b0;
	logic        wb_stb_i  = 1'b0;
	logic        wb_we_i   = 1'b0;
	logic [7:0]  wb_adr_i  = 8'h00;
	logic [3:0]  wb_sel_i  = 4'hF;
	logic [31:0] wb_dat_i  = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        pin_a_o;
	logic        pin_a_oe_n_o;
	logic        pin_b_o;
	logic        pin_b_oe_n_o;
	logic        level;
	logic [15:0] hi;
	logic [15:0] per;
	logic [15:0] rises;
	logic [31:0] rd;
	int          mismatches = 0;
	int          n_checks   = 0;

	// System clock, 100 ns period
	always #50 clk_sys_i = ~clk_sys_i;

	spwm_top dut (
		.clk_sys_i, .rstn_i, .sleep_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_a_o, .pin_a_oe_n_o, .pin_b_o, .pin_b_oe_n_o
	);
	spwm_load u_load (
		.clk_sys_i, .pin_a_i(pin_a_o), .pin_a_oe_n_i(pin_a_oe_n_o), .pin_b_i(pin_b_o),
		.pin_b_oe_n_i(pin_b_oe_n_o), .level_o(level), .hi_o(hi), .per_o(per), .rises_o(rises)
	);

	// Compare one value
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One classic cycle; read data lands in rd
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) chk("ack", 32'h1, 32'h0);
		@(posedge clk_sys_i);
	endtask

	task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
		wb(1'b0, adr, 32'h0);
		chk("reg", {24'h0, exp}, rd);
	endtask

	function automatic logic [7:0] ta(input int i, input logic [7:0] o);
		return 8'(spwm_pkg::OFS_TB_BASE + spwm_pkg::OFS_TB_STRIDE * i + o);
	endfunction

	// Wait for n rising edges on the wire, bounded
	task automatic wait_rises(input int n);
		logic [15:0] r0;
		int          c;
		r0 = rises;
		c = 0;
		while (int'(rises - r0) < n && c < 5000) begin
			@(posedge clk_sys_i);
			c++;
		end
		if (c >= 5000) chk("rise", 32'h1, 32'h0);
	endtask

	// Reset values, an unmapped address and the pin A enable
	task automatic t_reset;
		for (int a = 0; a < 8'h18; a += 4)
			rchk(8'(a), 8'(a) == spwm_pkg::OFS_PIN_DIRECTION ? spwm_pkg::RST_PIN_DIRECTION : 8'h00);
		rchk(8'hFC, 8'h00);
		// A write without byte lane 0 must be ignored
		wb_sel_i <= 4'hE;
		wb(1'b1, spwm_pkg::OFS_TIMEBASE_SEL, 32'h2);
		wb_sel_i <= 4'hF;
		rchk(spwm_pkg::OFS_TIMEBASE_SEL, spwm_pkg::RST_TIMEBASE_SEL);
		for (int i = 0; i < spwm_pkg::NUM_TIMEBASES; i++) begin
			rchk(ta(i, spwm_pkg::OFS_TB_PERIOD), spwm_pkg::RST_TB_PERIOD);
			rchk(ta(i, spwm_pkg::OFS_TB_CONTROL), spwm_pkg::RST_TB_CONTROL);
			rchk(ta(i, spwm_pkg::OFS_TB_COUNT), 8'h00);
			rchk(ta(i, spwm_pkg::OFS_TB_FLAG), 8'h00);
		end
		chk("oe_a", 32'h1, 32'(pin_a_oe_n_o));
	endtask

	// Safe setup on timer t, then measure one full period on the wire
	task automatic t_pwm(input int t, input logic [1:0] ps, input logic [7:0] p,
			input logic [9:0] d);
		int k;
		k = (ps == spwm_pkg::PSC_DIV1) ? 1 : (ps == spwm_pkg::PSC_DIV4) ? 4 : 16;
		wb(1'b1, spwm_pkg::OFS_PIN_DIRECTION, 32'h1);
		wb(1'b1, ta(t, spwm_pkg::OFS_TB_PERIOD), {24'h0, p});
		wb(1'b1, spwm_pkg::OFS_CHANNEL_CONTROL, {26'h0, d[1:0], spwm_pkg::MODE_PWM});
		wb(1'b1, spwm_pkg::OFS_DUTY_LOW_BYTE, {24'h0, d[9:2]});
		wb(1'b1, spwm_pkg::OFS_TIMEBASE_SEL, 32'(t));
		wb(1'b1, ta(t, spwm_pkg::OFS_TB_FLAG), 32'h1);
		wb(1'b1, ta(t, spwm_pkg::OFS_TB_CONTROL), {25'h0, 4'hF, 1'h1, ps});
		rd = 32'h0;
		repeat (600) if (rd[0] !== 1'b1) wb(1'b0, ta(t, spwm_pkg::OFS_TB_FLAG), 32'h0);
		chk("flag", 32'h1, rd);
		wb(1'b1, spwm_pkg::OFS_PIN_DIRECTION, 32'h0);
		wait_rises(3);
		chk("period", 32'(4 * (p + 1) * k), {16'h0, per});
		chk("high", 32'(d * k), {16'h0, hi});
	endtask

	// Duty written mid-period waits for the next period; shadow stays read-only
	task automatic t_update;
		wait_rises(1);
		wb(1'b1, spwm_pkg::OFS_DUTY_LOW_BYTE, 32'h2);
		rchk(spwm_pkg::OFS_DUTY_SHADOW_HIGH, 8'h09);
		wb(1'b1, spwm_pkg::OFS_DUTY_SHADOW_HIGH, 32'h55);
		wait_rises(1);
		chk("high_old", 32'h25, {16'h0, hi});
		wait_rises(1);
		chk("high_new", 32'h9, {16'h0, hi});
		rchk(spwm_pkg::OFS_DUTY_SHADOW_HIGH, 8'h02);
	endtask

	// Sleep freezes the wire; the period resumes unchanged on wake
	task automatic t_sleep;
		logic [15:0] r0;
		logic        lv;
		sleep_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		r0 = rises;
		lv = level;
		repeat (100) @(posedge clk_sys_i);
		chk("sleep_rises", {16'h0, r0}, {16'h0, rises});
		chk("sleep_level", 32'(lv), 32'(level));
		sleep_i <= 1'b0;
		wait_rises(2);
		chk("wake_period", 32'h40, {16'h0, per});
	endtask

	// Zero duty never sets the wire, an oversized duty leaves it alone
	task automatic t_limits;
		logic [15:0] r0;
		wb(1'b1, spwm_pkg::OFS_DUTY_LOW_BYTE, 32'h0);
		wb(1'b1, spwm_pkg::OFS_CHANNEL_CONTROL, {28'h0, spwm_pkg::MODE_PWM});
		repeat (130) @(posedge clk_sys_i);
		r0 = rises;
		repeat (200) @(posedge clk_sys_i);
		chk("zero_rises", {16'h0, r0}, {16'h0, rises});
		wb(1'b1, spwm_pkg::OFS_DUTY_LOW_BYTE, 32'hFF);
		repeat (200) @(posedge clk_sys_i);
		chk("over_rises", {16'h0, r0}, {16'h0, rises});
		chk("over_level", 32'h0, 32'(level));
	endtask

	// Position B drives the wire; a non-PWM mode and a cleared control release it
	task automatic t_pins;
		wb(1'b1, spwm_pkg::OFS_DUTY_LOW_BYTE, 32'h4);
		wb(1'b1, spwm_pkg::OFS_PIN_LOC_SEL_B, 32'h1);
		wait_rises(3);
		chk("oe_a", 32'h1, 32'(pin_a_oe_n_o));
		chk("high_b", 32'h10, {16'h0, hi});
		wb(1'b1, spwm_pkg::OFS_CHANNEL_CONTROL, {28'h0, ~spwm_pkg::MODE_PWM});
		repeat (3) @(posedge clk_sys_i);
		chk("mode_oe", 32'h1, 32'(pin_b_oe_n_o));
		wb(1'b1, spwm_pkg::OFS_CHANNEL_CONTROL, {28'h0, spwm_pkg::MODE_PWM});
		repeat (3) @(posedge clk_sys_i);
		chk("pwm_oe", 32'h0, 32'(pin_b_oe_n_o));
		wb(1'b1, spwm_pkg::OFS_CHANNEL_CONTROL, 32'h0);
		repeat (3) @(posedge clk_sys_i);
		chk("clear_oe", 32'h1, 32'(pin_b_oe_n_o));
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		mismatches++;
		report_and_stop();
	end

	// Main sequence, with a second reset in mid-run
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		@(posedge clk_sys_i);
		t_reset();
		t_pwm(0, spwm_pkg::PSC_DIV1, 8'hFF, 10'h3FF);
		t_pwm(1, spwm_pkg::PSC_DIV4, 8'h07, 10'h013);
		t_pwm(2, 2'h2, 8'h03, 10'h00B);
		t_pwm(0, spwm_pkg::PSC_DIV1, 8'h0F, 10'h025);
		t_update();
		t_sleep();
		t_limits();
		t_pins();
		rstn_i <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		@(posedge clk_sys_i);
		t_reset();
		report_and_stop();
	end
endmodule
